// ==== hdl/spos_map.vh ====
// Purpose: Constants for the status pin output select block
// Assumes: Included by every design file of the block
// Notes:   Definitions only
`ifndef SPOS_MAP_VH
`define SPOS_MAP_VH

// Configuration register layout
`define SPOS_CFG_W          16
`define SPOS_CFG_RESET      16'h0200
`define SPOS_CFG_WR_MASK    16'h1f1f
`define SPOS_SEL_HI         4
`define SPOS_SEL_LO         0
`define SPOS_SEL_W          5
`define SPOS_POL_BIT        8
`define SPOS_PU_BIT         9
`define SPOS_PD_BIT         10
`define SPOS_HIZ_BIT        11
`define SPOS_OD_BIT         12

// Source select codes
`define SPOS_SEL_APLL       5'h00
`define SPOS_SEL_DPLL       5'h01
`define SPOS_SEL_REF_LOS    5'h02
`define SPOS_SEL_XTAL_LOS   5'h04
`define SPOS_SEL_REF_ACT    5'h05
`define SPOS_SEL_REF_INV    5'h07
`define SPOS_SEL_DEV_INT    5'h09
`define SPOS_SEL_READY      5'h0a
`define SPOS_SEL_LOW        5'h1d
`define SPOS_SEL_HIGH       5'h1e
`define SPOS_SEL_NOPOL      5'h1f
`define SPOS_SEL_RDBK_MAX   5'h04

// Polarity values
`define SPOS_POL_ACT_HIGH   1'h0
`define SPOS_POL_ACT_LOW    1'h1

`endif

// ==== hdl/spos_src_mux.v ====
// Purpose: Picks the status source named by the select code
// Assumes: All sources synchronous to the block clock
// Notes:   Reserved codes give a low level
`timescale 1ns/1ps
`include "spos_map.vh"

module spos_src_mux #(
  parameter INT_W = 8
) (
  // Select
  input  wire [`SPOS_SEL_W-1:0] i_sel,
  // Status sources
  input  wire                   i_apll_lock,
  input  wire                   i_dpll_lock,
  input  wire                   i_reference_signal_loss_monitor,
  input  wire                   i_crystal_signal_loss_monitor,
  input  wire                   i_reference_activity_monitor,
  input  wire                   i_ref_invalid,
  input  wire [INT_W-1:0]       i_int_status,
  input  wire [INT_W-1:0]       i_int_enable,
  input  wire                   i_startup_done,
  // Result
  output reg                    o_value
);

  wire dev_int;

  assign dev_int = |(i_int_status & i_int_enable);

  always @* begin
    case (i_sel)
      `SPOS_SEL_APLL:     o_value = i_apll_lock;
      `SPOS_SEL_DPLL:     o_value = i_dpll_lock;
      `SPOS_SEL_REF_LOS:  o_value = i_reference_signal_loss_monitor;
      `SPOS_SEL_XTAL_LOS: o_value = i_crystal_signal_loss_monitor;
      `SPOS_SEL_REF_ACT:  o_value = i_reference_activity_monitor;
      `SPOS_SEL_REF_INV:  o_value = i_ref_invalid;
      `SPOS_SEL_DEV_INT:  o_value = dev_int;
      `SPOS_SEL_READY:    o_value = i_startup_done;
      `SPOS_SEL_LOW:      o_value = 1'b0;
      `SPOS_SEL_HIGH:     o_value = 1'b1;
      default:            o_value = 1'b0;
    endcase
  end

endmodule // spos_src_mux

// ==== hdl/spos_top.v ====
// Purpose: Status pin output select, polarity and drive control
// Assumes: Register port is the internal side of the serial port
// Notes:   Pin drive lags sources and config by one clock; pull enables follow config directly
`timescale 1ns/1ps
`include "spos_map.vh"

module spos_top #(
  parameter INT_W = 8
) (
  // Clock and reset
  input  wire                   i_clk,
  input  wire                   i_rst_n,
  // Configuration register port
  input  wire                   i_cfg_wr_en,
  input  wire [`SPOS_CFG_W-1:0] i_cfg_wr_data,
  output wire [`SPOS_CFG_W-1:0] o_cfg_rd_data,
  output wire                   o_pin_readback,
  // Status sources
  input  wire                   i_apll_lock,
  input  wire                   i_dpll_lock,
  input  wire                   i_reference_signal_loss_monitor,
  input  wire                   i_crystal_signal_loss_monitor,
  input  wire                   i_reference_activity_monitor,
  input  wire                   i_ref_invalid,
  input  wire [INT_W-1:0]       i_int_status,
  input  wire [INT_W-1:0]       i_int_enable,
  input  wire                   i_startup_done,
  // Status pin
  output wire                   o_status_pin_out,
  output wire                   o_status_pin_oe,
  output wire                   o_status_pin_pullup_en,
  output wire                   o_status_pin_pulldown_en
);

  reg  [`SPOS_CFG_W-1:0] status_pin_config_reg;
  reg  [`SPOS_CFG_W-1:0] status_pin_config_next;
  reg                    pin_out_reg;
  reg                    pin_out_next;
  reg                    pin_oe_reg;
  reg                    pin_oe_next;
  reg                    readback_reg;
  reg                    readback_next;
  wire [`SPOS_SEL_W-1:0] sel;
  wire                   selected;
  wire                   pol;
  wire                   adjusted;

  // Config fields
  assign sel = status_pin_config_reg[`SPOS_SEL_HI:`SPOS_SEL_LO];
  assign pol = status_pin_config_reg[`SPOS_POL_BIT];

  spos_src_mux #(
    .INT_W (INT_W)
  ) u_src_mux (
    .i_sel                           (sel),
    .i_apll_lock                     (i_apll_lock),
    .i_dpll_lock                     (i_dpll_lock),
    .i_reference_signal_loss_monitor (i_reference_signal_loss_monitor),
    .i_crystal_signal_loss_monitor   (i_crystal_signal_loss_monitor),
    .i_reference_activity_monitor    (i_reference_activity_monitor),
    .i_ref_invalid                   (i_ref_invalid),
    .i_int_status                    (i_int_status),
    .i_int_enable                    (i_int_enable),
    .i_startup_done                  (i_startup_done),
    .o_value                         (selected)
  );

  // Polarity applies except on the no-polarity code
  function apply_pol;
    input [`SPOS_SEL_W-1:0] f_sel;
    input                   f_pol;
    input                   f_val;
    begin
      if (f_sel == `SPOS_SEL_NOPOL) begin
        apply_pol = f_val;
      end else if (f_pol == `SPOS_POL_ACT_LOW) begin
        apply_pol = ~f_val;
      end else begin
        apply_pol = f_val;
      end
    end
  endfunction

  assign adjusted = apply_pol(sel, pol, selected);

  // Reserved bits are never stored, so they read back as zero
  always @* begin
    status_pin_config_next = status_pin_config_reg;
    if (i_cfg_wr_en) begin
      status_pin_config_next = i_cfg_wr_data & `SPOS_CFG_WR_MASK;
    end
  end

  // Driver control; pull-down with open drain is left to software
  always @* begin
    pin_out_next = adjusted;
    pin_oe_next  = 1'b1;
    if (status_pin_config_reg[`SPOS_HIZ_BIT]) begin
      pin_out_next = 1'b0;
      pin_oe_next  = 1'b0;
    end else if (status_pin_config_reg[`SPOS_OD_BIT]) begin
      pin_out_next = 1'b0;
      pin_oe_next  = ~adjusted;
    end
  end

  // Readback follows the polarity-adjusted level for select codes up to 0x04, even when tristated, and is zero above that
  always @* begin
    readback_next = 1'b0;
    if (sel <= `SPOS_SEL_RDBK_MAX) begin
      readback_next = adjusted;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_pin_config_reg <= `SPOS_CFG_RESET;
      pin_out_reg           <= 1'b0;
      pin_oe_reg            <= 1'b0;
      readback_reg          <= 1'b0;
    end else begin
      status_pin_config_reg <= status_pin_config_next;
      pin_out_reg           <= pin_out_next;
      pin_oe_reg            <= pin_oe_next;
      readback_reg          <= readback_next;
    end
  end

  assign o_cfg_rd_data            = status_pin_config_reg;
  assign o_pin_readback           = readback_reg;
  assign o_status_pin_out         = pin_out_reg;
  assign o_status_pin_oe          = pin_oe_reg;
  assign o_status_pin_pullup_en   = status_pin_config_reg[`SPOS_PU_BIT];
  assign o_status_pin_pulldown_en = status_pin_config_reg[`SPOS_PD_BIT];

endmodule // spos_top

// ==== verification/spos_checker.sv ====
// Purpose: Port assertions for spos_top
// Assumes: Pins lag config and sources by one clock
// Notes:   Bound after the module
`timescale 1ns/1ps
module spos_checker (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_cfg_wr_en,
  input wire [15:0] i_cfg_wr_data,
  input wire [15:0] o_cfg_rd_data,
  input wire        o_pin_readback,
  input wire        i_apll_lock,
  input wire        o_status_pin_out,
  input wire        o_status_pin_oe
);
  wire [15:0] c   = o_cfg_rd_data;
  wire [4:0]  s   = c[4:0];
  wire        pol = c[8];
  wire        pp  = !c[11] && !c[12];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_write_take: assert property (i_cfg_wr_en |=>
    c == ($past(i_cfg_wr_data) & 16'h1f1f)) else $error("write lost");
  a_reset_value: assert property ($rose(i_rst_n) |->
    c == 16'h0200) else $error("bad reset value");
  a_hiz_release: assert property (c[11] |=>
    !o_status_pin_oe && !o_status_pin_out) else $error("pin not released");
  a_od_low: assert property (c[12] && !c[11] |=>
    !o_status_pin_out) else $error("open drain drives high");
  a_low_const: assert property (pp && s == 5'h1d |=>
    o_status_pin_out == $past(pol)) else $error("low level wrong");
  a_high_const: assert property (pp && s == 5'h1e |=>
    o_status_pin_out == !$past(pol)) else $error("high level wrong");
  a_nopol_zero: assert property (pp && s == 5'h1f |=>
    !o_status_pin_out && o_status_pin_oe) else $error("polarity applied");
  a_apll_path: assert property (pp && s == 5'h00 && !pol && i_apll_lock
    |=> o_status_pin_out) else $error("lock not shown");
  a_readback_zero: assert property (s > 5'h04 |=>
    !o_pin_readback) else $error("readback not zero");
endmodule // spos_checker
bind spos_top spos_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_cfg_wr_en(i_cfg_wr_en), .i_cfg_wr_data(i_cfg_wr_data),
  .o_cfg_rd_data(o_cfg_rd_data), .o_pin_readback(o_pin_readback),
  .i_apll_lock(i_apll_lock), .o_status_pin_out(o_status_pin_out),
  .o_status_pin_oe(o_status_pin_oe));

// ==== verification/spos_board.sv ====
// Purpose: Board wire on the status pin
// Assumes: Pulls weaker than any driver
// Notes:   Unpulled float toggles, never a stale level
`timescale 1ns/1ps
module spos_board (
  input  wire  i_clk,
  input  wire  i_out,
  input  wire  i_oe,
  input  wire  i_pu,
  input  wire  i_pd,
  output logic o_level
);
  logic last = 1'b0;
  assign o_level = i_oe ? i_out : i_pu ? 1'b1 : i_pd ? 1'b0 : ~last;
  always @(posedge i_clk) last <= o_level;
endmodule // spos_board

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for spos_top
// Assumes: Pins settle one clock after config
// Notes:   Sources and config from xorshift
`timescale 1ns/1ps
module testbench;
  logic        i_clk = 0;
  logic        i_rst_n = 0;
  logic        wr = 0;
  logic [15:0] wd = 0;
  logic [15:0] c, rd;
  logic [31:0] r;
  logic [6:0]  src = 0;
  logic [7:0]  st = 0;
  logic [7:0]  en = 0;
  logic [2:0]  e;
  logic        o_out, o_oe, o_pu, o_pd, o_rb, lvl;
  logic [31:0] seed = 32'h0a81;
  int          err_total = 0;
  int          n_checks = 0;
  logic [4:0]  codes [11] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h07,
                             5'h09, 5'h0a, 5'h1d, 5'h1e, 5'h1f};
  always #5 i_clk = ~i_clk;
  spos_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_wr_en(wr),
    .i_cfg_wr_data(wd), .o_cfg_rd_data(rd), .o_pin_readback(o_rb),
    .i_apll_lock(src[0]), .i_dpll_lock(src[1]),
    .i_reference_signal_loss_monitor(src[2]),
    .i_crystal_signal_loss_monitor(src[3]),
    .i_reference_activity_monitor(src[4]), .i_ref_invalid(src[5]),
    .i_startup_done(src[6]), .i_int_status(st), .i_int_enable(en),
    .o_status_pin_out(o_out), .o_status_pin_oe(o_oe),
    .o_status_pin_pullup_en(o_pu), .o_status_pin_pulldown_en(o_pd));
  spos_board u_board (.i_clk(i_clk), .i_out(o_out), .i_oe(o_oe),
    .i_pu(o_pu), .i_pd(o_pd), .o_level(lvl));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] mdl(input logic [15:0] k);
    logic v;
    logic a;
    logic rb;
    case (k[4:0])
      5'h00: v = src[0];
      5'h01: v = src[1];
      5'h02: v = src[2];
      5'h04: v = src[3];
      5'h05: v = src[4];
      5'h07: v = src[5];
      5'h09: v = |(st & en);
      5'h0a: v = src[6];
      5'h1e: v = 1'b1;
      default: v = 1'b0;
    endcase
    a = (k[4:0] == 5'h1f) ? v : v ^ k[8];
    rb = (k[4:0] <= 5'h04) & a;
    return k[11] ? {2'b00, rb} : k[12] ? {1'b0, ~a, rb} : {a, 1'b1, rb};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1;
    @(negedge i_clk) chk(rd, 16'h0200);
    for (int i = 0; i < 88; i++) begin
      @(negedge i_clk);
      r = xs();
      src = r[22:16] | 7'(i < 11);
      st = r[30:23];
      r = xs();
      en = r[23:16];
      // Pull-down kept off in open drain; junk in reserved bits
      c = (r[15:0] & (i < 11 ? 16'he2e0 : 16'hfbe0)) | {5'h0,
          r[10] & ~r[12], 5'h0, codes[i % 11]};
      wd = c ^ 16'h0100;
      wr = 1;
      @(negedge i_clk) wd = c;
      @(negedge i_clk) wr = 0;
      @(negedge i_clk);
      chk(rd, c & 16'h1f1f);
      e = mdl(c);
      chk({o_out, o_oe, o_rb}, e);
      chk({o_out, o_oe, o_rb}, e);
      chk({o_pd, o_pu}, c[10:9]);
      if (e[1] | c[9] | c[10]) chk(lvl, e[1] ? e[2] : c[9]);
    end
    @(negedge i_clk) i_rst_n = 0;
    @(negedge i_clk) chk({rd, o_pu, o_oe}, {16'h0200, 2'b10});
    i_rst_n = 1;
    @(negedge i_clk) chk({o_out, o_oe, o_rb}, mdl(16'h0200));
    wrap_up();
  end
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
endmodule // testbench
